// ### rtl/cci_pkg.sv
// constants and types of the codec control command interpreter
//==============================================================
// Operation
// - first serial byte after select is command
// - serial select rise aborts remaining registers
// - monitor transfers never abort, exact byte count
// - global addresses 0-25 and 28 decode
// - global registers auto-decrement like local ones
// - monitor global commands accepted in any slot
// - coefficient memory 40 words, five blocks
// - coefficient write keeps upper fourteen bits
// - coefficient read gives sixteen bits, msb first
// - monitor channel from slot pins and b4
// - memory command moves eight words, highest first
// - serial select rise aborts remaining words
// - pattern memory four blocks of eight words
// - pattern block moves eight words, abortable serially
// - serial read sends identification byte first
// - command bit7 direction, bits 6-5 type
// - register count from address bits 1-0
// - memory bit b4 picks coefficient or pattern
`default_nettype none
package cci_pkg;
  //==============================================================
  // command fields
  localparam logic [1:0] CT_LOCAL   = 2'h0;
  localparam logic [1:0] CT_GLOBAL  = 2'h1;
  localparam logic [1:0] CT_BAD     = 2'h2;
  localparam logic [1:0] CT_MEM     = 2'h3;
  localparam logic [2:0] PS_HI      = 3'h4;
  localparam logic [3:0] PS_LO      = 4'h1;
  //==============================================================
  // sizes and addresses
  localparam int         NCH        = 8;
  localparam int         LREG_N     = 32;
  localparam int         GREG_N     = 27;
  localparam logic [4:0] GREG_SPAN  = 5'h1a;
  localparam logic [4:0] GREG_LAST  = 5'h1c;
  localparam logic [4:0] GREG_CHEN  = 5'h05;
  localparam logic [4:0] GREG_PSEL  = 5'h18;
  localparam int         COEF_WORDS = 40;
  localparam logic [3:0] COEF_BLKS  = 4'h5;
  localparam int         NGEN       = 4;
  localparam int         PAT_WORDS  = 32;
  localparam logic [4:0] MEM_BYTES  = 5'h10;
  localparam logic [7:0] GREG_RST   = 8'h00;
  //==============================================================
  // control states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_CMD  = 6'h02,
    S_PREP = 6'h04,
    S_DATA = 6'h08,
    S_MRD  = 6'h10,
    S_WAIT = 6'h20
  } cci_state_t;
endpackage
`default_nettype wire

// ### rtl/cci_link_shift.sv
// host serial port shifter on the link clock
`timescale 1ns/1ps
`default_nettype none
module cci_link_shift
  import cci_pkg::*;
(
  input  wire logic       lk_clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       serial_command_in,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_tog,
  output logic            serial_data_out
);
  logic       lk_arst_n;
  logic [2:0] bit_r, bit_nxt;
  logic [6:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic       tog_r, tog_nxt;

  //==============================================================
  // bit counter restarts while select is high
  assign lk_arst_n = rst_n & ~cs_n;

  always_comb begin
    bit_nxt = bit_r + 3'h1;
    sh_nxt  = {sh_r[5:0], serial_command_in};
    tx_nxt  = {tx_r[6:0], 1'b0};
    rx_nxt  = rx_r;
    tog_nxt = tog_r;
    if (bit_r == 3'h7) begin
      rx_nxt  = {sh_r, serial_command_in};
      tog_nxt = ~tog_r;
      tx_nxt  = tx_byte;
    end
  end

  always_ff @(posedge lk_clk or negedge lk_arst_n) begin
    if (!lk_arst_n) begin
      bit_r <= 3'h0;
      sh_r  <= 7'h00;
      tx_r  <= 8'h00;
    end else begin
      bit_r <= bit_nxt;
      sh_r  <= sh_nxt;
      tx_r  <= tx_nxt;
    end
  end

  always_ff @(posedge lk_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r  <= 8'h00;
      tog_r <= 1'b0;
    end else begin
      rx_r  <= rx_nxt;
      tog_r <= tog_nxt;
    end
  end

  assign rx_byte         = rx_r;
  assign rx_tog          = tog_r;
  assign serial_data_out = tx_r[7];
endmodule
`default_nettype wire

// ### rtl/cci_cmd_core.sv
// command interpreter: decode, register files and memories
`timescale 1ns/1ps
`default_nettype none
module cci_cmd_core
  import cci_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5a // arbitrary value
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       host_sclk,
  input  wire logic       cs_n,
  input  wire logic       serial_command_in,
  output logic            serial_data_out,
  input  wire logic       mon_valid,
  input  wire logic [7:0] mon_byte,
  input  wire logic [1:0] mon_slot,
  input  wire logic [1:0] slot_select_pin,
  output logic            mon_tx_valid,
  output logic      [7:0] mon_tx_byte,
  output logic      [7:0] chan_enable,
  output logic      [3:0] pattern_select,
  output logic            busy,
  output logic            cmd_error
);
  //==============================================================
  // helpers
  function automatic logic [2:0] low_ch(input logic [7:0] m);
    low_ch = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) low_ch = 3'(i);
    end
  endfunction

  function automatic logic glob_ok(input logic [4:0] a);
    glob_ok = (a < GREG_SPAN) || (a == GREG_LAST);
  endfunction

  function automatic logic [4:0] glob_idx(input logic [4:0] a);
    glob_idx = (a == GREG_LAST) ? GREG_SPAN : a;
  endfunction

  //==============================================================
  // link side and crossings
  logic [7:0] rx_byte;
  logic       rx_tog;
  logic       cs_m_r, cs_s_r, cs_d_r;
  logic       tg_m_r, tg_s_r, tg_d_r;
  logic [1:0] ts_m_r, ts_s_r;
  logic [7:0] tx_r, tx_nxt;

  cci_link_shift u_link (
    .lk_clk            (host_sclk),
    .rst_n             (rst_n),
    .cs_n              (cs_n),
    .serial_command_in (serial_command_in),
    .tx_byte           (tx_r),
    .rx_byte           (rx_byte),
    .rx_tog            (rx_tog),
    .serial_data_out   (serial_data_out)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      tg_m_r <= 1'b0;
      tg_s_r <= 1'b0;
      tg_d_r <= 1'b0;
      ts_m_r <= 2'h0;
      ts_s_r <= 2'h0;
    end else if (ce) begin
      cs_m_r <= cs_n;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      tg_m_r <= rx_tog;
      tg_s_r <= tg_m_r;
      tg_d_r <= tg_s_r;
      ts_m_r <= slot_select_pin;
      ts_s_r <= ts_m_r;
    end
  end

  //==============================================================
  // storage
  logic [7:0]  lreg [NCH][LREG_N];
  logic [7:0]  greg [GREG_N];
  logic [13:0] coef [NCH][COEF_WORDS];
  logic [15:0] pat  [NGEN][PAT_WORDS];

  //==============================================================
  // control state
  cci_state_t st_r, st_nxt;
  logic       src_mon_r, src_mon_nxt;
  logic       wr_r, wr_nxt;
  logic [1:0] ct_r, ct_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] tgt_r, tgt_nxt;
  logic       ab_r, ab_nxt;
  logic       slot_ok_r, slot_ok_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic       mtv_r, mtv_nxt;
  logic [7:0] mtb_r, mtb_nxt;
  logic       err_r, err_nxt;
  logic       busy_r;
  logic       cs_rise, cs_fall, ev, cmd_ev, do_wr, step, hi_ph, mem_ok;
  logic [7:0] in_b, rd_byte, ps_up;
  logic [4:0] reg_len;
  logic [2:0] wd;

  assign cs_rise = cs_s_r & ~cs_d_r;
  assign cs_fall = ~cs_s_r & cs_d_r;
  assign ev      = src_mon_r ? mon_valid : (tg_s_r ^ tg_d_r);
  assign in_b    = src_mon_r ? mon_byte : rx_byte;
  assign cmd_ev  = ev && (st_r == S_CMD);
  assign reg_len = {3'h0, in_b[1:0]} + 5'h1;
  assign wd      = 3'((cnt_r - 5'h1) >> 1);
  assign hi_ph   = ~cnt_r[0];
  assign ps_up   = {PS_HI, ab_r, PS_LO};
  assign mem_ok  = addr_r[4] ? (addr_r[3:2] == 2'h0) : (addr_r[3:0] < COEF_BLKS);

  //==============================================================
  // read byte selection
  always_comb begin
    logic [13:0] cw;
    logic [15:0] pw;
    cw      = coef[low_ch(tgt_r)][{addr_r[2:0], wd}];
    pw      = pat[2'(low_ch({4'h0, greg[GREG_PSEL][3:0]}))][{addr_r[1:0], wd}];
    rd_byte = 8'h00;
    unique case (ct_r)
      CT_LOCAL:  rd_byte = lreg[low_ch(tgt_r)][addr_r];
      CT_GLOBAL: rd_byte = glob_ok(addr_r) ? greg[glob_idx(addr_r)] : 8'h00;
      CT_MEM: begin
        if (mem_ok && !addr_r[4]) begin
          rd_byte = hi_ph ? cw[13:6] : {cw[5:0], 2'h0};
        end else if (mem_ok) begin
          rd_byte = hi_ph ? pw[15:8] : pw[7:0];
        end
      end
      default:   rd_byte = 8'h00;
    endcase
  end

  //==============================================================
  // sequencer
  always_comb begin
    st_nxt      = st_r;
    src_mon_nxt = src_mon_r;
    wr_nxt      = wr_r;
    ct_nxt      = ct_r;
    addr_nxt    = addr_r;
    cnt_nxt     = cnt_r;
    tgt_nxt     = tgt_r;
    ab_nxt      = ab_r;
    slot_ok_nxt = slot_ok_r;
    tx_nxt      = tx_r;
    mtv_nxt     = 1'b0;
    mtb_nxt     = mtb_r;
    err_nxt     = err_r;
    do_wr       = 1'b0;
    step        = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        tx_nxt = ID_CODE;
        if (cs_fall) begin
          st_nxt      = S_CMD;
          src_mon_nxt = 1'b0;
        end else if (mon_valid && cs_s_r && mon_byte[7:5] == PS_HI && mon_byte[3:0] == PS_LO) begin
          st_nxt      = S_CMD;
          src_mon_nxt = 1'b1;
          ab_nxt      = mon_byte[4];
          slot_ok_nxt = (mon_slot == ts_s_r);
        end
      end
      S_CMD: begin
        if (ev) begin
          wr_nxt   = in_b[7];
          ct_nxt   = in_b[6:5];
          addr_nxt = in_b[4:0];
          err_nxt  = (in_b[6:5] == CT_BAD);
          cnt_nxt  = (in_b[6:5] == CT_MEM) ? MEM_BYTES : reg_len;
          tgt_nxt  = src_mon_r ? 8'(8'h01 << {ts_s_r, ab_r}) : greg[GREG_CHEN];
          if (in_b[6:5] == CT_BAD) begin
            st_nxt = src_mon_r ? S_IDLE : S_WAIT;
          end else if (src_mon_r && in_b[6:5] != CT_GLOBAL && !slot_ok_r) begin
            st_nxt = S_IDLE;
          end else if (in_b[7]) begin
            st_nxt = S_DATA;
          end else if (src_mon_r) begin
            st_nxt  = S_MRD;
            mtv_nxt = 1'b1;
            mtb_nxt = ps_up;
          end else begin
            st_nxt = S_PREP;
          end
        end
      end
      S_PREP: begin
        tx_nxt = rd_byte;
        step   = 1'b1;
        st_nxt = S_DATA;
      end
      S_DATA: begin
        if (ev && wr_r) begin
          do_wr = 1'b1;
          step  = 1'b1;
          if (cnt_r == 5'h1) begin
            st_nxt = src_mon_r ? S_IDLE : S_WAIT;
          end
        end else if (ev && cnt_r == 5'h0) begin
          st_nxt = S_WAIT;
        end else if (ev) begin
          tx_nxt = rd_byte;
          step   = 1'b1;
        end
      end
      S_MRD: begin
        if (cnt_r == 5'h0) begin
          st_nxt = S_IDLE;
        end else begin
          mtv_nxt = 1'b1;
          mtb_nxt = rd_byte;
          step    = 1'b1;
        end
      end
      S_WAIT: st_nxt = S_WAIT;
    endcase
    if (step) begin
      cnt_nxt = cnt_r - 5'h1;
      if (ct_r != CT_MEM) begin
        addr_nxt = addr_r - 5'h1;
      end
    end
    if (cs_rise && !src_mon_r && st_r != S_IDLE) begin
      st_nxt = S_IDLE;
    end
  end

  always_comb begin
    hi_nxt = (do_wr && hi_ph) ? in_b : hi_r;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= S_IDLE;
      src_mon_r <= 1'b0;
      wr_r      <= 1'b0;
      ct_r      <= CT_LOCAL;
      addr_r    <= 5'h00;
      cnt_r     <= 5'h00;
      tgt_r     <= 8'h00;
      ab_r      <= 1'b0;
      slot_ok_r <= 1'b0;
      hi_r      <= 8'h00;
      tx_r      <= 8'h00;
      mtv_r     <= 1'b0;
      mtb_r     <= 8'h00;
      err_r     <= 1'b0;
      busy_r    <= 1'b0;
    end else if (ce) begin
      st_r      <= st_nxt;
      src_mon_r <= src_mon_nxt;
      wr_r      <= wr_nxt;
      ct_r      <= ct_nxt;
      addr_r    <= addr_nxt;
      cnt_r     <= cnt_nxt;
      tgt_r     <= tgt_nxt;
      ab_r      <= ab_nxt;
      slot_ok_r <= slot_ok_nxt;
      hi_r      <= hi_nxt;
      tx_r      <= tx_nxt;
      mtv_r     <= mtv_nxt;
      mtb_r     <= mtb_nxt;
      err_r     <= err_nxt;
      busy_r    <= (st_nxt != S_IDLE);
    end
  end

  //==============================================================
  // register and memory writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        for (int r = 0; r < LREG_N; r++) begin
          lreg[c][r] <= GREG_RST;
        end
      end
      for (int g = 0; g < GREG_N; g++) begin
        greg[g] <= GREG_RST;
      end
    end else if (ce && do_wr) begin
      for (int c = 0; c < NCH; c++) begin
        if (ct_r == CT_LOCAL && tgt_r[c]) begin
          lreg[c][addr_r] <= in_b;
        end
      end
      if (ct_r == CT_GLOBAL && glob_ok(addr_r)) begin
        greg[glob_idx(addr_r)] <= in_b;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && do_wr && ct_r == CT_MEM && !hi_ph && mem_ok) begin
      for (int c = 0; c < NCH; c++) begin
        if (!addr_r[4] && tgt_r[c]) begin
          coef[c][{addr_r[2:0], wd}] <= {hi_r, in_b[7:2]};
        end
      end
      for (int g = 0; g < NGEN; g++) begin
        if (addr_r[4] && greg[GREG_PSEL][g]) begin
          pat[g][{addr_r[1:0], wd}] <= {hi_r, in_b};
        end
      end
    end
  end

  assign mon_tx_valid   = mtv_r;
  assign mon_tx_byte    = mtb_r;
  assign chan_enable    = greg[GREG_CHEN];
  assign pattern_select = greg[GREG_PSEL][3:0];
  assign busy           = busy_r;
  assign cmd_error      = err_r;

  //==============================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ser_abort;
    ce && cs_rise && !src_mon_r && st_r != S_IDLE;
  endsequence
  sequence s_mon_read;
    ce && cmd_ev && src_mon_r && !in_b[7] && in_b[6:5] == CT_GLOBAL;
  endsequence

  property p_id_first;
    (ce && cmd_ev && !src_mon_r && !in_b[7]) |-> tx_r == ID_CODE;
  endproperty
  a_id_first: assert property (p_id_first) else $error("id byte not staged");

  property p_ser_abort;
    s_ser_abort |=> st_r == S_IDLE && !busy_r;
  endproperty
  a_ser_abort: assert property (p_ser_abort) else $error("select rise did not abort");

  property p_mon_hold;
    (ce && src_mon_r && st_r == S_DATA && !mon_valid) |=> st_r == S_DATA;
  endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("monitor transfer dropped");

  property p_bad_type;
    (ce && cmd_ev && in_b[6:5] == CT_BAD) |=> err_r && st_r != S_DATA && st_r != S_PREP;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("bad type accepted");

  property p_reg_cnt;
    (ce && cmd_ev && !in_b[6]) |=> cnt_r == $past(reg_len);
  endproperty
  a_reg_cnt: assert property (p_reg_cnt) else $error("register count wrong");

  property p_mem_cnt;
    (ce && cmd_ev && in_b[6:5] == CT_MEM) |=> cnt_r == MEM_BYTES;
  endproperty
  a_mem_cnt: assert property (p_mem_cnt) else $error("memory count wrong");

  property p_mon_slot;
    (ce && cmd_ev && src_mon_r && !slot_ok_r && in_b[6:5] == CT_LOCAL) |=> st_r == S_IDLE;
  endproperty
  a_mon_slot: assert property (p_mon_slot) else $error("foreign slot accepted");

  property p_mon_glob;
    s_mon_read |=> mtv_r && mtb_r == ps_up;
  endproperty
  a_mon_glob: assert property (p_mon_glob) else $error("global read not answered");
endmodule
`default_nettype wire

// ### sim/cci_host_model.sv
// host-side model of the serial port: select, shift clock, command bits
`timescale 1ns/1ps
`default_nettype none
module cci_host_model (
  output var logic host_sclk,
  output var logic cs_n,
  output var logic serial_command_in,
  input  wire logic serial_data_out
);
  //==============================================================
  // idle: shift clock stands low, select high
  initial begin
    host_sclk         = 1'b0;
    cs_n              = 1'b1;
    serial_command_in = 1'b0;
  end
  //==============================================================
  // framing
  task automatic open_cmd;
    #300 cs_n = 1'b0;
  endtask
  task automatic close_cmd;
    #84 cs_n = 1'b1;
    #300;
  endtask
  //==============================================================
  // one byte, msb first, gap before it for the core
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    #600;
    for (int i = 7; i >= 0; i--) begin
      serial_command_in = b[i];
      #6 r[i] = serial_data_out;
      host_sclk = 1'b1;
      #6 host_sclk = 1'b0;
    end
    serial_command_in = ~b[0];
  endtask
endmodule
`default_nettype wire

// ### sim/cci_cmd_core_tb_top.sv
// bench of the codec control command interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); bad_count++; end end
module cci_cmd_core_tb_top
  import cci_pkg::*;
;
  localparam logic [7:0] TB_ID = 8'h3c; // arbitrary value
  typedef struct { logic [7:0] cmd; logic [3:0] zm; } cci_row_t;
  cci_row_t   rows [6] = '{'{8'ha3, 4'h0}, '{8'h83, 4'h0}, '{8'hbc, 4'h0},
                           '{8'hba, 4'h1}, '{8'he4, 4'h0}, '{8'hf3, 4'h0}};
  logic       core_clk, rst_n, ce, host_sclk, cs_n, serial_command_in;
  logic       serial_data_out, mon_valid, mon_tx_valid, busy, cmd_error;
  logic [7:0] mon_byte, mon_tx_byte, chan_enable;
  logic [1:0] mon_slot, slot_select_pin;
  logic [3:0] pattern_select;
  logic [7:0] dat [17];
  logic [7:0] rx  [17];
  logic [7:0] up_q [$];
  int         bad_count, compares, n;

  cci_cmd_core #(.ID_CODE(TB_ID)) cci_cmd_core_i (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .host_sclk(host_sclk), .cs_n(cs_n),
    .serial_command_in(serial_command_in), .serial_data_out(serial_data_out),
    .mon_valid(mon_valid), .mon_byte(mon_byte), .mon_slot(mon_slot),
    .slot_select_pin(slot_select_pin), .mon_tx_valid(mon_tx_valid),
    .mon_tx_byte(mon_tx_byte), .chan_enable(chan_enable),
    .pattern_select(pattern_select), .busy(busy), .cmd_error(cmd_error));
  cci_host_model cci_host_model_i (
    .host_sclk(host_sclk), .cs_n(cs_n), .serial_command_in(serial_command_in),
    .serial_data_out(serial_data_out));

  //==============================================================
  // clock and upstream capture
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (mon_tx_valid === 1'b1) up_q.push_back(mon_tx_byte);
  end
  //==============================================================
  // helpers
  task automatic fill(input int k);
    for (int i = 0; i < 17; i++) dat[i] = {k[3:0], i[3:0]};
  endtask
  task automatic hs(input logic [7:0] c, input int cnt);
    logic [7:0] j;
    cci_host_model_i.open_cmd();
    cci_host_model_i.xfer(c, j);
    for (int i = 0; i < cnt; i++) cci_host_model_i.xfer(dat[i], rx[i]);
    cci_host_model_i.close_cmd();
  endtask
  function automatic int count(input logic [7:0] c);
    return (c[6:5] == CT_MEM) ? 16 : int'(c[1:0]) + 1;
  endfunction
  function automatic logic [7:0] expv(input int k, input int i, input cci_row_t r);
    logic [7:0] e;
    e = {k[3:0], i[3:0]};
    if (r.cmd[6:5] == CT_MEM && !r.cmd[4] && i[0]) e = e & 8'hfc;
    if (i < 4 && r.zm[i]) e = 8'h00;
    return e;
  endfunction
  task automatic mon_seq(input logic [7:0] b [4], input int cnt, input logic [1:0] s, input bit gap);
    up_q.delete();
    for (int i = 0; i < cnt; i++) begin
      @(posedge core_clk);
      mon_valid <= 1'b1;
      mon_byte  <= b[i];
      mon_slot  <= s;
      if (gap) begin
        @(posedge core_clk);
        mon_valid <= 1'b0;
      end
    end
    @(posedge core_clk);
    mon_valid <= 1'b0;
    mon_byte  <= ~b[cnt-1];
    mon_slot  <= ~s;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  //==============================================================
  // watchdog
  initial begin
    #2ms;
    bad_count++;
    test_done();
  end
  //==============================================================
  // main sequence
  initial begin
    rst_n           = 1'b0;
    ce              = 1'b1;
    mon_valid       = 1'b0;
    mon_byte        = 8'h00;
    mon_slot        = 2'h0;
    slot_select_pin = 2'h0;
    repeat (20) @(posedge core_clk);
    `CHK("reset outs", 24'h0, {serial_data_out, mon_tx_valid, mon_tx_byte, chan_enable,
         pattern_select, busy, cmd_error})
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    dat[0] = 8'h01;
    dat[1] = 8'h00;
    hs(8'ha5, 2);
    `CHK("chan_enable", 8'h01, chan_enable)
    // table rows: write, then read back
    for (int r = 0; r < 6; r++) begin
      n = count(rows[r].cmd);
      fill(r + 1);
      hs(rows[r].cmd, n);
      hs(rows[r].cmd & 8'h7f, n + 1);
      `CHK("id byte", TB_ID, rx[0])
      for (int i = 0; i < n; i++) begin
        `CHK("readback", expv(r + 1, i, rows[r]), rx[i+1])
      end
    end
    `CHK("pattern_select", 4'h2, pattern_select)
    // register abort after two bytes
    fill(9);
    hs(8'ha3, 2);
    hs(8'h23, 5);
    for (int i = 0; i < 4; i++) begin
      `CHK("reg abort", {(i < 2) ? 4'h9 : 4'h1, i[3:0]}, rx[i+1])
    end
    // memory abort in the middle of the second word
    fill(10);
    hs(8'hf3, 3);
    hs(8'h73, 17);
    for (int i = 0; i < 16; i++) begin
      `CHK("mem abort", {(i < 2) ? 4'ha : 4'h6, i[3:0]}, rx[i+1])
    end
    hs(8'h40, 1);
    `CHK("cmd_error", 1'b1, cmd_error)
    `CHK("busy idle", 1'b0, busy)
    cci_host_model_i.open_cmd();
    repeat (4) @(posedge core_clk);
    `CHK("busy open", 1'b1, busy)
    cci_host_model_i.close_cmd();
    // monitor channel, first write with idle cycles between bytes
    mon_seq('{8'h81, 8'h81, 8'h77, 8'h66}, 4, 2'h0, 1'b1);
    `CHK("cmd_error clr", 1'b0, cmd_error)
    mon_seq('{8'h81, 8'h01, 8'h00, 8'h00}, 2, 2'h0, 1'b0);
    `CHK("mon count", 3, up_q.size())
    `CHK("mon read", 24'h817766, {up_q[0], up_q[1], up_q[2]})
    mon_seq('{8'h81, 8'h01, 8'h00, 8'h00}, 2, 2'h3, 1'b0);
    `CHK("mon other slot", 0, up_q.size())
    mon_seq('{8'h81, 8'h38, 8'h00, 8'h00}, 2, 2'h3, 1'b0);
    `CHK("mon global", 16'h8142, {up_q[0], up_q[1]})
    // clock enable low freezes the interpreter
    ce <= 1'b0;
    mon_seq('{8'h81, 8'h38, 8'h00, 8'h00}, 2, 2'h3, 1'b0);
    `CHK("ce freeze", 0, up_q.size())
    ce <= 1'b1;
    test_done();
  end
endmodule
`default_nettype wire
